// >>> logic/lcd_pkg.sv
// Shared constants for the segment display driver
package lcd_pkg;
   // Bank pointer value that maps the display memory
   localparam logic [7:0] DISP_BANK = 8'h01;
   // First indirect address of display memory
   localparam logic [7:0] DISP_BASE = 8'h80;
   // Display memory depth in bytes, one byte per segment line
   localparam int DISP_DEPTH = 32;
   localparam int DISP_AW = 5;
   // Control register field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_DUTY_BIT = 5;
   localparam int CTRL_BIAS_BIT = 6;
   localparam int CTRL_TYPE_BIT = 7;
   // Control register reset value and writable mask
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'hE1;
   // Sub clock divide ratio toward the driver clock
   localparam int SUB_DIV = 8;
   // Commons per duty setting
   localparam int COMS_QUARTER = 4;
   localparam int COMS_SIXTH = 6;
   localparam int MAX_COMS = 6;
   // Drive level codes on each line (ground, low, middle, top bias)
   typedef enum logic [1:0] {
      LVL_GND = 2'b00,
      LVL_VC = 2'b01,
      LVL_VB = 2'b10,
      LVL_VA = 2'b11
   } level_t;
endpackage

// >>> logic/lcd_clk_div.sv
// Divider that turns sub clock ticks into driver clock enables
`timescale 1ns/1ns
module lcd_clk_div #(
   parameter int DIV = lcd_pkg::SUB_DIV
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic run_in,
   input wire logic sub_tick_in,
   output logic drv_tick_out
);
   // Tick counter, wide enough for the ratio
   logic [$clog2(DIV)-1:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   // Count sub ticks, pulse on the last one of each group
   always_comb begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!run_in) begin
         // Held at zero while idle so the first frame starts clean
         cnt_d = '0;
      end else if (sub_tick_in) begin
         if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   // Register stage
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign drv_tick_out = tick_q;
endmodule

// >>> logic/lcd_segment_driver.sv
// Segment display driver: control register, display memory and scan
`timescale 1ns/1ns
// How it works
// [R1] Software loads bank pointer with 01H first
// [R2] Bank 1 indirect accesses from 80H hit display
// [R3] Direct accesses fall through to bank 0
// [R4] Scanner reads display memory every slot
// [R5] Enable bit works except in sleep
// [R6] Bit 7 picks Type A or Type B
// [R7] Type B toggles polarity per frame, slower
// [R8] Bit 6 picks top bias level
// [R9] Bit 5 picks quarter or sixth duty
// [R10] Unimplemented control bits read zero
// [R11] Control register resets to zero
// [R12] Driver clock is sub clock over 8
// [R13] Sub clock source fixed by option
// [R14] Disabled driver holds every line at ground
// [R15] Polarity alternation keeps pixel DC at zero
// [R16] One slot per active common each frame
// [R17] Software initialises display memory after power-up
// [R18] Segment select level when memory bit set
// [R19] Duty and type change at frame boundary
module lcd_segment_driver #(
   parameter int SEGS = lcd_pkg::DISP_DEPTH,
   parameter int COMS = lcd_pkg::MAX_COMS
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   // Data memory access from the core
   input wire logic [7:0] bank_pointer_in,
   input wire logic indirect_in,
   input wire logic [7:0] mem_addr_in,
   input wire logic mem_we_in,
   input wire logic mem_re_in,
   input wire logic [7:0] mem_wdata_in,
   output logic disp_hit_out,
   output logic [7:0] disp_rdata_out,
   // Control register port from the special register decoder
   input wire logic ctrl_we_in,
   input wire logic [7:0] ctrl_wdata_in,
   output logic [7:0] display_control_reg_out,
   // Power mode and clock source
   input wire logic sleep_in,
   input wire logic osc_select_in,
   input wire logic internal_low_rc_osc_tick_in,
   input wire logic external_low_crystal_tick_in,
   // Panel drive level codes, two bits per line
   output logic [2*COMS-1:0] common_line_out,
   output logic [2*SEGS-1:0] segment_line_out,
   output logic bias_top_select_out,
   output logic drive_active_out
);
   // Control register
   logic [7:0] ctrl_q, ctrl_d;
   // Display memory, left unreset on purpose: software fills it
   logic [7:0] mem_q [SEGS];
   logic [7:0] rdata_q, rdata_d;
   // Scan state
   logic [2:0] slot_q, slot_d;
   logic phase_q, phase_d;
   logic pol_q, pol_d;
   logic type_act_q, type_act_d;
   logic duty_act_q, duty_act_d;
   // Output registers
   logic [2*COMS-1:0] com_q, com_d;
   logic [2*SEGS-1:0] seg_q, seg_d;
   // Misc
   logic hit;
   logic enabled;
   logic sub_tick;
   logic drv_tick;
   logic [2:0] last_slot;
   logic frame_end;
   logic drive_pol;

   // Address decode of an access aimed at display memory
   function automatic logic disp_decode(input logic [7:0] bp, input logic ind, input logic [7:0] a);
      disp_decode = ind && (bp == lcd_pkg::DISP_BANK) && (a >= lcd_pkg::DISP_BASE) &&
                    (a < lcd_pkg::DISP_BASE + 8'(SEGS));
   endfunction

   // Level of a line for a given polarity: selected or not
   function automatic logic [1:0] line_level(input logic is_com, input logic sel, input logic pol);
      logic [1:0] lv;
      lv = lcd_pkg::LVL_GND;
      if (is_com) begin
         lv = sel ? (pol ? lcd_pkg::LVL_GND : lcd_pkg::LVL_VA) : (pol ? lcd_pkg::LVL_VB : lcd_pkg::LVL_VC);
      end else begin
         lv = sel ? (pol ? lcd_pkg::LVL_VA : lcd_pkg::LVL_GND) : (pol ? lcd_pkg::LVL_VC : lcd_pkg::LVL_VB);
      end
      line_level = lv;
   endfunction

   // Only indirect bank 1 accesses are claimed; direct ones go to bank 0
   assign hit = disp_decode(bank_pointer_in, indirect_in, mem_addr_in); // [R2] [R3]
   assign disp_hit_out = hit;

   // Enable bit ignored while sleeping
   assign enabled = ctrl_q[lcd_pkg::CTRL_EN_BIT] && !sleep_in; // [R5]

   // Fixed option picks the low speed oscillator
   assign sub_tick = osc_select_in ? external_low_crystal_tick_in : internal_low_rc_osc_tick_in; // [R13]

   // Driver clock enable from the sub clock
   lcd_clk_div #(
      .DIV(lcd_pkg::SUB_DIV)
   ) u_div (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .run_in(enabled),
      .sub_tick_in(sub_tick),
      .drv_tick_out(drv_tick)
   ); // [R12]

   // Control register update, writable bits only
   always_comb begin
      ctrl_d = ctrl_q;
      if (ctrl_we_in) begin
         ctrl_d = ctrl_wdata_in & lcd_pkg::CTRL_MASK; // [R10]
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ctrl_q <= lcd_pkg::CTRL_RESET; // [R11]
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Unimplemented bits are never stored, so they read zero
   assign display_control_reg_out = ctrl_q; // [R10]
   assign bias_top_select_out = ctrl_q[lcd_pkg::CTRL_BIAS_BIT]; // [R8]

   // Index of a display byte from a claimed address
   function automatic logic [lcd_pkg::DISP_AW-1:0] disp_index(input logic [7:0] a);
      logic [7:0] off;
      off = a - lcd_pkg::DISP_BASE;
      disp_index = off[lcd_pkg::DISP_AW-1:0];
   endfunction

   // Read data for a display memory read
   always_comb begin
      rdata_d = rdata_q;
      if (hit && mem_re_in) begin
         rdata_d = mem_q[disp_index(mem_addr_in)];
      end
   end

   // Memory write; no reset so the array stays plain storage
   always_ff @(posedge clk_in) begin
      if (hit && mem_we_in) begin
         mem_q[disp_index(mem_addr_in)] <= mem_wdata_in; // [R2]
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign disp_rdata_out = rdata_q;

   // Last slot of the frame under the active duty
   assign last_slot = duty_act_q ? 3'(lcd_pkg::COMS_SIXTH - 1) : 3'(lcd_pkg::COMS_QUARTER - 1); // [R9] [R16]
   assign frame_end = drv_tick && phase_q && (slot_q == last_slot);
   // Type A inverts inside each slot, Type B once per frame
   assign drive_pol = type_act_q ? pol_q : phase_q; // [R6] [R7] [R15]

   // Slot sequencer: each slot spans two driver ticks
   always_comb begin
      slot_d = slot_q;
      phase_d = phase_q;
      pol_d = pol_q;
      type_act_d = type_act_q;
      duty_act_d = duty_act_q;
      if (!enabled) begin
         // Idle: restart at slot zero and track settings freely
         slot_d = 3'h0;
         phase_d = 1'b0;
         pol_d = 1'b0;
         type_act_d = ctrl_q[lcd_pkg::CTRL_TYPE_BIT];
         duty_act_d = ctrl_q[lcd_pkg::CTRL_DUTY_BIT];
      end else if (drv_tick) begin
         phase_d = !phase_q;
         if (phase_q) begin
            if (frame_end) begin
               slot_d = 3'h0; // [R16]
               pol_d = !pol_q; // [R15]
               // New settings only between frames
               type_act_d = ctrl_q[lcd_pkg::CTRL_TYPE_BIT]; // [R19]
               duty_act_d = ctrl_q[lcd_pkg::CTRL_DUTY_BIT]; // [R19]
            end else begin
               slot_d = slot_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         slot_q <= 3'h0;
         phase_q <= 1'b0;
         pol_q <= 1'b0;
         type_act_q <= 1'b0;
         duty_act_q <= 1'b0;
      end else begin
         slot_q <= slot_d;
         phase_q <= phase_d;
         pol_q <= pol_d;
         type_act_q <= type_act_d;
         duty_act_q <= duty_act_d;
      end
   end

   // Line levels, recomputed from live memory every cycle
   always_comb begin
      com_d = '0;
      seg_d = '0;
      if (enabled) begin
         for (int c = 0; c < COMS; c++) begin
            // Commons beyond the duty stay grounded
            if (c <= int'(last_slot)) begin
               com_d[2*c +: 2] = line_level(1'b1, slot_q == 3'(c), drive_pol); // [R16]
            end
         end
         for (int s = 0; s < SEGS; s++) begin
            // Sixth duty drives two fewer segments
            if (!(duty_act_q && s >= SEGS - 2)) begin
               seg_d[2*s +: 2] = line_level(1'b0, mem_q[s][slot_q], drive_pol); // [R4] [R18]
            end
         end
      end
   end // [R14]

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         com_q <= '0;
         seg_q <= '0;
      end else begin
         com_q <= com_d;
         seg_q <= seg_d;
      end
   end

   assign common_line_out = com_q;
   assign segment_line_out = seg_q;
   assign drive_active_out = enabled;
endmodule

// >>> sim/lcd_segment_driver_props.sv
// Port checker for the segment display driver
`timescale 1ns/1ns
module lcd_segment_driver_props #(
   parameter int SEGS = 32,
   parameter int COMS = 6
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] bank_pointer_in,
   input wire logic indirect_in,
   input wire logic [7:0] mem_addr_in,
   input wire logic ctrl_we_in,
   input wire logic [7:0] ctrl_wdata_in,
   input wire logic [7:0] display_control_reg_out,
   input wire logic sleep_in,
   input wire logic disp_hit_out,
   input wire logic drive_active_out,
   input wire logic [2*COMS-1:0] common_line_out,
   input wire logic [2*SEGS-1:0] segment_line_out,
   input wire logic bias_top_select_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_hit_decode: assert property (disp_hit_out == (indirect_in && bank_pointer_in == 8'h01 &&
      mem_addr_in[7:5] == 3'h4)) else $error("display hit decode wrong");
   a_ctrl_write: assert property (ctrl_we_in |=> display_control_reg_out == ($past(ctrl_wdata_in) & 8'hE1))
      else $error("control write wrong");
   a_ctrl_hold: assert property (!ctrl_we_in |=> $stable(display_control_reg_out))
      else $error("control changed without write");
   a_active_rule: assert property (drive_active_out == (display_control_reg_out[0] && !sleep_in))
      else $error("drive active wrong");
   a_blank_off: assert property (!drive_active_out |=> common_line_out == '0 && segment_line_out == '0)
      else $error("lines not blank");
   // Bias select tracks the stored bit on every cycle, not only when quiet
   a_bias_follow: assert property (bias_top_select_out == display_control_reg_out[6])
      else $error("bias select wrong");
   // Only one of the first four commons may be addressed at a time
   a_one_common: assert property (common_line_out[7:0] != '0 |-> $onehot0({common_line_out[7] ~^
      common_line_out[6], common_line_out[5] ~^ common_line_out[4], common_line_out[3] ~^ common_line_out[2],
      common_line_out[1] ~^ common_line_out[0]})) else $error("two commons selected");
   a_seg_levels: assert property (common_line_out[1:0] == 2'b11 |->
      (segment_line_out & {SEGS{2'b01}}) == '0) else $error("segment polarity wrong");
endmodule
bind lcd_segment_driver lcd_segment_driver_props #(.SEGS(SEGS), .COMS(COMS)) i_props (.clk_in, .rstn_in,
   .bank_pointer_in, .indirect_in, .mem_addr_in, .ctrl_we_in, .ctrl_wdata_in, .display_control_reg_out, .sleep_in,
   .disp_hit_out, .drive_active_out, .common_line_out, .segment_line_out, .bias_top_select_out);

// >>> sim/lcd_panel_model.sv
// Passive glass model watching the first common
`timescale 1ns/1ns
module lcd_panel_model (
   input wire logic clk_in,
   input wire logic [11:0] com_in,
   input wire logic [63:0] seg_in,
   output int dc_out,
   output logic [31:0] lit_out
);
   initial dc_out = 0;
   // Pixel DC each cycle, dark pixels only while the first common is at LVL_VA
   always @(posedge clk_in) begin
      dc_out <= dc_out + int'(com_in[1:0]) - int'(seg_in[1:0]);
      // Full swing across a pixel means dark
      if (com_in[1:0] == 2'b11) begin
         for (int s = 0; s < 32; s++) lit_out[s] <= seg_in[2*s+:2] == 2'b00;
      end
   end
endmodule

// >>> sim/lcd_segment_driver_test.sv
// Self-checking bench for the segment display driver
`timescale 1ns/1ns
module lcd_segment_driver_test;
   logic clk_in = 0, rstn_in = 0, indirect_in = 0, mem_we_in = 0, mem_re_in = 0, ctrl_we_in = 0, sleep_in = 0;
   logic osc_select_in = 1, internal_low_rc_osc_tick_in = 0, external_low_crystal_tick_in = 1;
   logic disp_hit_out, bias_top_select_out, drive_active_out;
   logic [7:0] bank_pointer_in = 0, mem_addr_in = 0, mem_wdata_in = 0, ctrl_wdata_in = 0;
   logic [7:0] disp_rdata_out, display_control_reg_out;
   logic [11:0] common_line_out;
   logic [63:0] segment_line_out;
   logic [31:0] seed = 32'hF108, lit;
   int fails = 0, n_tests = 0, cyc = 0, dc, img[32];
   always #5 clk_in = ~clk_in;
   // Slow source at half rate
   always @(posedge clk_in) internal_low_rc_osc_tick_in <= ~internal_low_rc_osc_tick_in;
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end
   lcd_segment_driver i_dut (.clk_in, .rstn_in, .bank_pointer_in, .indirect_in, .mem_addr_in, .mem_we_in,
      .mem_re_in, .mem_wdata_in, .disp_hit_out, .disp_rdata_out, .ctrl_we_in, .ctrl_wdata_in,
      .display_control_reg_out, .sleep_in, .osc_select_in, .internal_low_rc_osc_tick_in,
      .external_low_crystal_tick_in, .common_line_out, .segment_line_out, .bias_top_select_out, .drive_active_out);
   lcd_panel_model i_panel (.clk_in, .com_in(common_line_out), .seg_in(segment_line_out), .dc_out(dc), .lit_out(lit));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic ctrl(input logic [7:0] v);
      ctrl_wdata_in = v;
      ctrl_we_in = 1;
      tick();
      ctrl_we_in = 0;
      tick();
      check(display_control_reg_out, v & 8'hE1);
      check(bias_top_select_out, v[6]);
   endtask
   // One memory cycle; for reads d is the expected byte
   // An idle edge follows, so back-to-back calls never retoggle a strobe in one step
   task automatic mem(input logic ind, input logic [7:0] bp, a, input logic we, input logic [7:0] d, input logic hit);
      indirect_in = ind;
      bank_pointer_in = bp;
      mem_addr_in = a;
      mem_wdata_in = d;
      mem_we_in = we;
      mem_re_in = !we;
      tick();
      // Address still stands here, so the claim is seen settled
      check(disp_hit_out, hit);
      if (!we) check(disp_rdata_out, d);
      mem_we_in = 0;
      mem_re_in = 0;
      tick();
   endtask
   // Waits for the next start of a selected first common at LVL_VA
   task automatic edge3(output longint t, output int d);
      for (int n = 0; n < 3000 && common_line_out[1:0] == 2'b11; n++) tick();
      for (int n = 0; n < 3000 && common_line_out[1:0] != 2'b11; n++) tick();
      t = $time;
      d = dc;
   endtask
   task automatic end_sim();
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      longint t0, t1;
      int d0, d1;
      logic [7:0] v;
      tick(5);
      rstn_in = 1;
      check(display_control_reg_out, 8'h00);
      check({common_line_out, segment_line_out}, '0);
      for (int s = 0; s < 32; s++) begin
         img[s] = rnd() & 255;
         mem(1, 8'h01, 8'(128 + s), 1, 8'(img[s]), 1);
      end
      mem(0, 8'h01, 8'h80, 1, 8'h5A, 0);
      mem(1, 8'h00, 8'h81, 1, 8'h5A, 0);
      for (int s = 0; s < 32; s++) mem(1, 8'h01, 8'(128 + s), 0, 8'(img[s]), 1);
      // Every type, duty and clock source
      for (int k = 0; k < 8; k++) begin
         osc_select_in = k[2];
         v = 8'(rnd());
         v[7] = k[0];
         v[5] = k[1];
         v[0] = 1;
         ctrl(v);
         edge3(t0, d0);
         edge3(t0, d0);
         edge3(t1, d1);
         check((t1 - t0) / 10, (k[1] ? 6 : 4) * 16 * (k[0] ? 2 : 1) * (k[2] ? 1 : 2));
         check(d1 - d0, 0);
      end
      ctrl(8'h01);
      repeat (2) begin
         repeat (3) edge3(t0, d0);
         for (int s = 0; s < 32; s++) check(lit[s], img[s] & 1);
         img[0] ^= 1;
         mem(1, 8'h01, 8'h80, 1, 8'(img[0]), 1);
      end
      sleep_in = 1;
      tick(2);
      check({drive_active_out, common_line_out, segment_line_out}, '0);
      sleep_in = 0;
      tick(2);
      check(drive_active_out, 1);
      ctrl(8'h00);
      tick(2);
      check({common_line_out, segment_line_out}, '0);
      end_sim();
   end
endmodule
